// *** core/flash_host_pkg.sv ***
package flash_host_pkg;
	// apb register map of the controller
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] addr_off = 8'h04;
	localparam logic [7:0] data_off = 8'h08;
	localparam logic [7:0] data2_off = 8'h0C;
	localparam logic [7:0] stat_off = 8'h10;
	localparam logic [7:0] rdata_off = 8'h14;
	// ctrl field layout
	localparam int cmd_lsb = 0;
	localparam int cmd_w = 4;
	localparam int go_bit = 8;
	// stat field layout
	localparam int busy_bit = 0;
	localparam int done_bit = 1;
	localparam int fail_bit = 2;
	localparam int timeout_bit = 3;
	// host operations
	typedef enum logic [3:0] {
		op_read = 4'h0,
		op_reset = 4'h1,
		op_bypass_word = 4'h2,
		op_bypass_pair = 4'h3,
		op_leave_bypass = 4'h4,
		op_guard = 4'h5,
		op_unguard = 4'h6,
		op_freeze = 4'h7,
		op_block_wipe = 4'h8,
		op_bank_wipe = 4'h9,
		op_pause = 4'hA,
		op_continue = 4'hB
	} host_op_t;
	// flash command codes
	localparam logic [7:0] code_aa = 8'hAA;
	localparam logic [7:0] code_55 = 8'h55;
	localparam logic [7:0] code_reset = 8'hF0;
	localparam logic [7:0] code_prog = 8'hA0;
	localparam logic [7:0] code_pair = 8'h40;
	localparam logic [7:0] code_leave1 = 8'h90;
	localparam logic [7:0] code_leave2 = 8'h00;
	localparam logic [7:0] code_guard_pre = 8'h60;
	localparam logic [7:0] code_guard = 8'h01;
	localparam logic [7:0] code_unguard = 8'hD0;
	localparam logic [7:0] code_freeze = 8'h2F;
	localparam logic [7:0] code_wipe_pre = 8'h80;
	localparam logic [7:0] code_block_wipe = 8'h30;
	localparam logic [7:0] code_bank_wipe = 8'h10;
	localparam logic [7:0] code_pause = 8'hB0;
	localparam logic [7:0] code_continue = 8'h30;
	localparam logic [10:0] unlock_a = 11'h555;
	localparam logic [10:0] unlock_b = 11'h2AA;
	// status bit positions
	localparam int poll_bit = 7;
	localparam int toggle_bit_a = 6;
	localparam int fail_flag = 5;
	localparam logic [7:0] status_mask = 8'hE4;
	// strobe timing
	localparam int strobe_ns = 60;
	localparam int clk_ns = 10;
	localparam int strobe_cyc = (strobe_ns + clk_ns - 1) / clk_ns;
	localparam int addr_w = 21;
	localparam int data_w = 16;
endpackage : flash_host_pkg

// *** core/flash_bus_cycle.sv ***
`timescale 1ns/10ps
// one asynchronous flash write or read cycle, timed in core clocks
module flash_bus_cycle (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [flash_host_pkg::addr_w-1:0] addr_i,
	input wire logic [flash_host_pkg::data_w-1:0] wdata_i,
	input wire logic [flash_host_pkg::data_w-1:0] dq_in_i,
	output logic done_o,
	output logic [flash_host_pkg::data_w-1:0] rdata_o,
	output logic [flash_host_pkg::addr_w-1:0] addr_o,
	output logic [flash_host_pkg::data_w-1:0] dq_out_o,
	output logic dq_oe_o,
	output logic chip_select_n_o,
	output logic write_strobe_n_o,
	output logic output_strobe_n_o
);
	import flash_host_pkg::*;
	typedef enum logic [3:0] {
		c_idle = 4'b0001,
		c_act = 4'b0010,
		c_samp = 4'b0100,
		c_rec = 4'b1000
	} cyc_st_t;
	cyc_st_t st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic [addr_w-1:0] a_q, a_d;
	logic [data_w-1:0] wd_q, wd_d, rd_q, rd_d;
	logic [data_w-1:0] sync1_q, sync2_q;
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		a_d = a_q;
		wd_d = wd_q;
		rd_d = rd_q;
		unique case (st_q)
			c_idle: begin
				if (start_i) begin
					st_d = c_act;
					wr_d = write_i;
					a_d = addr_i;
					wd_d = wdata_i;
					cnt_d = 8'(strobe_cyc);
				end
			end
			c_act: begin
				if (cnt_q == 8'h00) begin
					st_d = c_samp;
					cnt_d = 8'h02;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			c_samp: begin
				// sampled data passes two flops first
				if (cnt_q == 8'h00) begin
					rd_d = sync2_q;
					st_d = c_rec;
					cnt_d = 8'(strobe_cyc);
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			c_rec: begin
				if (cnt_q == 8'h00) begin
					st_d = c_idle;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st_q <= c_idle;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			a_q <= '0;
			wd_q <= '0;
			rd_q <= '0;
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			a_q <= a_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			sync1_q <= dq_in_i;
			sync2_q <= sync1_q;
		end
	end
	// chip select and strobe fall per cycle, so each read is a fresh toggle sample
	assign chip_select_n_o = !(st_q == c_act || st_q == c_samp);
	assign write_strobe_n_o = !(st_q == c_act && wr_q);
	assign output_strobe_n_o = !((st_q == c_act || st_q == c_samp) && !wr_q);
	assign dq_oe_o = (st_q == c_act || st_q == c_samp) && wr_q;
	assign dq_out_o = wd_q;
	assign addr_o = a_q;
	assign rdata_o = rd_q;
	assign done_o = (st_q == c_rec) && (cnt_q == 8'h00);
endmodule : flash_bus_cycle

// *** core/flash_host_ctrl.sv ***
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module flash_host_ctrl #(
	parameter int poll_limit = 100000
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [flash_host_pkg::addr_w-1:0] addr_o,
	output logic [flash_host_pkg::data_w-1:0] dq_out_o,
	output logic dq_oe_o,
	input wire logic [flash_host_pkg::data_w-1:0] dq_in_i,
	output logic chip_select_n_o,
	output logic write_strobe_n_o,
	output logic output_strobe_n_o
);
	import flash_host_pkg::*;
	typedef enum logic [4:0] {
		s_idle = 5'b00001,
		s_write = 5'b00010,
		s_read = 5'b00100,
		s_poll = 5'b01000,
		s_done = 5'b10000
	} host_st_t;
	host_st_t st_q, st_d;
	logic [3:0] cmd_q, cmd_d;
	logic [addr_w-1:0] taddr_q, taddr_d;
	logic [data_w-1:0] tdata_q, tdata_d, tdata2_q, tdata2_d, rdat_q, rdat_d;
	logic [2:0] step_q, step_d;
	logic busy_q, busy_d, done_q, done_d, fail_q, fail_d, tout_q, tout_d;
	logic have_prev_q, have_prev_d;
	logic [7:0] prev_q, prev_d;
	logic [31:0] pcnt_q, pcnt_d;
	logic cyc_start, cyc_wr, cyc_done;
	logic [addr_w-1:0] cyc_addr;
	logic [data_w-1:0] cyc_data, cyc_rdata;
	logic [7:0] stat_now;
	logic [2:0] last_step;
	logic is_poll_op;
	// number of write cycles per operation, last index
	function automatic logic [2:0] steps_of(input logic [3:0] c);
		unique case (host_op_t'(c))
			op_bypass_word, op_leave_bypass: steps_of = 3'd1;
			op_bypass_pair: steps_of = 3'd2;
			op_guard, op_unguard, op_freeze: steps_of = 3'd3;
			op_block_wipe, op_bank_wipe: steps_of = 3'd5;
			default: steps_of = 3'd0;
		endcase
	endfunction : steps_of
	// address and data for a given step
	function automatic logic [addr_w+data_w-1:0] cycle_of(input logic [3:0] c, input logic [2:0] s,
		input logic [addr_w-1:0] a, input logic [data_w-1:0] d, input logic [data_w-1:0] d2);
		logic [addr_w-1:0] ua, ub;
		logic [7:0] fin;
		ua = {a[addr_w-1:11], unlock_a};
		ub = {a[addr_w-1:11], unlock_b};
		fin = code_guard;
		cycle_of = {a, d};
		unique case (host_op_t'(c))
			op_reset: cycle_of = {a, 8'h00, code_reset};
			op_bypass_word: cycle_of = (s == 3'd0) ? {a, 8'h00, code_prog} : {a, d};
			op_bypass_pair: begin
				// second address differs only in bit zero
				if (s == 3'd0) cycle_of = {a, 8'h00, code_pair};
				else if (s == 3'd1) cycle_of = {a[addr_w-1:1], 1'b0, d};
				else cycle_of = {a[addr_w-1:1], 1'b1, d2};
			end
			op_leave_bypass: cycle_of = {a, 8'h00, (s == 3'd0) ? code_leave1 : code_leave2};
			op_guard, op_unguard, op_freeze: begin
				if (host_op_t'(c) == op_unguard) fin = code_unguard;
				else if (host_op_t'(c) == op_freeze) fin = code_freeze;
				unique case (s)
					3'd0: cycle_of = {ua, 8'h00, code_aa};
					3'd1: cycle_of = {ub, 8'h00, code_55};
					3'd2: cycle_of = {ua, 8'h00, code_guard_pre};
					default: cycle_of = {a, 8'h00, fin};
				endcase
			end
			op_block_wipe, op_bank_wipe: begin
				unique case (s)
					3'd0, 3'd3: cycle_of = {ua, 8'h00, code_aa};
					3'd1, 3'd4: cycle_of = {ub, 8'h00, code_55};
					3'd2: cycle_of = {ua, 8'h00, code_wipe_pre};
					default: cycle_of = {a, 8'h00,
						(host_op_t'(c) == op_block_wipe) ? code_block_wipe : code_bank_wipe};
				endcase
			end
			op_pause: cycle_of = {a, 8'h00, code_pause};
			op_continue: cycle_of = {a, 8'h00, code_continue};
			default: cycle_of = {a, d};
		endcase
	endfunction : cycle_of
	flash_bus_cycle u_cycle (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.start_i(cyc_start),
		.write_i(cyc_wr),
		.addr_i(cyc_addr),
		.wdata_i(cyc_data),
		.dq_in_i(dq_in_i),
		.done_o(cyc_done),
		.rdata_o(cyc_rdata),
		.addr_o(addr_o),
		.dq_out_o(dq_out_o),
		.dq_oe_o(dq_oe_o),
		.chip_select_n_o(chip_select_n_o),
		.write_strobe_n_o(write_strobe_n_o),
		.output_strobe_n_o(output_strobe_n_o)
	);
	assign last_step = steps_of(cmd_q);
	assign {cyc_addr, cyc_data} = (st_q == s_write) ? cycle_of(cmd_q, step_q, taddr_q, tdata_q, tdata2_q)
		: {(cmd_q == op_bypass_pair) ? {taddr_q[addr_w-1:1], 1'b1} : taddr_q, tdata_q};
	assign cyc_wr = (st_q == s_write);
	assign stat_now = cyc_rdata[7:0] & status_mask;
	// program, wipe and continue are followed by polling
	assign is_poll_op = cmd_q inside {op_bypass_word, op_bypass_pair, op_block_wipe, op_bank_wipe, op_continue};
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			ctrl_off: prdata = {28'h000_0000, cmd_q};
			addr_off: prdata = {11'h000, taddr_q};
			data_off: prdata = {16'h0000, tdata_q};
			data2_off: prdata = {16'h0000, tdata2_q};
			stat_off: prdata = {28'h000_0000, tout_q, fail_q, done_q, busy_q};
			rdata_off: prdata = {16'h0000, rdat_q};
			default: prdata = 32'h0000_0000;
		endcase
	end
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		taddr_d = taddr_q;
		tdata_d = tdata_q;
		tdata2_d = tdata2_q;
		rdat_d = rdat_q;
		step_d = step_q;
		busy_d = busy_q;
		done_d = done_q;
		fail_d = fail_q;
		tout_d = tout_q;
		have_prev_d = have_prev_q;
		prev_d = prev_q;
		pcnt_d = pcnt_q;
		cyc_start = 1'b0;
		if (psel && penable && pwrite && st_q == s_idle) begin
			unique case (paddr)
				ctrl_off: begin
					cmd_d = pwdata[cmd_lsb +: cmd_w];
					if (pwdata[go_bit]) begin
						busy_d = 1'b1;
						done_d = 1'b0;
						fail_d = 1'b0;
						tout_d = 1'b0;
						step_d = 3'd0;
						st_d = (pwdata[cmd_lsb +: cmd_w] == op_read) ? s_read : s_write;
					end
				end
				addr_off: taddr_d = pwdata[addr_w-1:0];
				data_off: tdata_d = pwdata[data_w-1:0];
				data2_off: tdata2_d = pwdata[data_w-1:0];
				default: ;
			endcase
		end
		unique case (st_q)
			s_idle: ;
			s_write: begin
				cyc_start = !cyc_done;
				if (cyc_done) begin
					if (step_q == last_step) begin
						// polling starts after the last strobe only
						have_prev_d = 1'b0;
						pcnt_d = 32'h0000_0000;
						st_d = is_poll_op ? s_poll : s_done;
					end else begin
						step_d = step_q + 3'd1;
						cyc_start = 1'b0;
					end
				end
			end
			s_read: begin
				cyc_start = !cyc_done;
				if (cyc_done) begin
					rdat_d = cyc_rdata;
					st_d = s_done;
				end
			end
			s_poll: begin
				// every poll is a separate chip select cycle
				cyc_start = !cyc_done;
				if (cyc_done) begin
					rdat_d = cyc_rdata;
					prev_d = stat_now;
					have_prev_d = 1'b1;
					pcnt_d = pcnt_q + 32'h0000_0001;
					if (have_prev_q && prev_q[toggle_bit_a] == stat_now[toggle_bit_a]) begin
						st_d = s_done;
					end else if (stat_now[fail_flag] && have_prev_q && prev_q[fail_flag]) begin
						fail_d = 1'b1;
						st_d = s_done;
					end else if (pcnt_q == 32'(poll_limit)) begin
						tout_d = 1'b1;
						st_d = s_done;
					end
				end
			end
			s_done: begin
				busy_d = 1'b0;
				done_d = 1'b1;
				st_d = s_idle;
			end
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st_q <= s_idle;
			cmd_q <= 4'h0;
			taddr_q <= '0;
			tdata_q <= '0;
			tdata2_q <= '0;
			rdat_q <= '0;
			step_q <= 3'd0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			tout_q <= 1'b0;
			have_prev_q <= 1'b0;
			prev_q <= 8'h00;
			pcnt_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			taddr_q <= taddr_d;
			tdata_q <= tdata_d;
			tdata2_q <= tdata2_d;
			rdat_q <= rdat_d;
			step_q <= step_d;
			busy_q <= busy_d;
			done_q <= done_d;
			fail_q <= fail_d;
			tout_q <= tout_d;
			have_prev_q <= have_prev_d;
			prev_q <= prev_d;
			pcnt_q <= pcnt_d;
		end
	end
endmodule : flash_host_ctrl

// *** bench/flash_host_ctrl_chk.sv ***
`timescale 1ns/10ps
module flash_host_ctrl_chk import flash_host_pkg::*; #(
	parameter int poll_limit = 20
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [addr_w-1:0] addr_o,
	input wire logic [data_w-1:0] dq_out_o,
	input wire logic dq_oe_o,
	input wire logic [data_w-1:0] dq_in_i,
	input wire logic chip_select_n_o,
	input wire logic write_strobe_n_o,
	input wire logic output_strobe_n_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_wr_width: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*7] ##1 write_strobe_n_o)
		else $error("write strobe width wrong");
	a_cs_recover: assert property ($rose(chip_select_n_o) |-> chip_select_n_o [*7])
		else $error("chip select recovery too short");
	a_read_cs: assert property (!output_strobe_n_o |-> !chip_select_n_o && !dq_oe_o)
		else $error("read strobe without select or with drive");
	a_wr_drive: assert property (!write_strobe_n_o |-> !chip_select_n_o && dq_oe_o && output_strobe_n_o)
		else $error("write strobe without select or drive");
	a_addr_hold: assert property (!chip_select_n_o && $past(!chip_select_n_o) |-> $stable(addr_o))
		else $error("address moved in a cycle");
	a_data_hold: assert property (!write_strobe_n_o && $past(!write_strobe_n_o) |-> $stable(dq_out_o))
		else $error("write data moved under strobe");
	a_apb_ready: assert property (psel && penable |-> pready && !pslverr)
		else $error("apb access not completed cleanly");
	a_idle_quiet: assert property (chip_select_n_o |-> write_strobe_n_o && output_strobe_n_o)
		else $error("strobe while deselected");
	c_write: cover property ($fell(write_strobe_n_o));
	c_read: cover property ($fell(output_strobe_n_o));
	c_go: cover property (psel && penable && pwrite && paddr == ctrl_off);
endmodule : flash_host_ctrl_chk

bind flash_host_ctrl flash_host_ctrl_chk #(.poll_limit(poll_limit)) u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .addr_o(addr_o), .dq_out_o(dq_out_o), .dq_oe_o(dq_oe_o),
	.dq_in_i(dq_in_i), .chip_select_n_o(chip_select_n_o), .write_strobe_n_o(write_strobe_n_o),
	.output_strobe_n_o(output_strobe_n_o));

// *** bench/flash_dev_model.sv ***
`timescale 1ns/10ps
module flash_dev_model (
	input wire logic [20:0] addr_i,
	input wire logic [15:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic chip_select_n_i,
	input wire logic write_strobe_n_i,
	input wire logic output_strobe_n_i,
	input wire logic fail_i,
	input wire logic hang_i,
	output logic [15:0] dq_o
);
	logic [15:0] mem [logic [20:0]];
	logic [15:0] sd [0:5];
	logic [20:0] sa [0:5];
	logic [7:0] pc [0:4] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
	logic [10:0] pa [0:4] = '{11'h555, 11'h2AA, 11'h555, 11'h555, 11'h2AA};
	logic [15:0] pd, rd;
	logic [20:0] ta;
	logic [7:0] guard_q, wipe_q;
	logic busy, er, bank_w, susp_q, fail_q, tog, g, ok, hit;
	int n, cnt, left_n;
	initial begin
		{busy, er, bank_w, susp_q, fail_q, tog, rd, n, cnt, left_n, guard_q, wipe_q} = '0;
	end
	// released bus shows the inverse of the last value
	assign dq_o = (!chip_select_n_i && !output_strobe_n_i && !dq_oe_i) ? rd : ~rd;
	task start(input logic e, input logic [20:0] a, input logic [15:0] d);
		busy = 1;
		er = e;
		ta = a;
		pd = d;
		cnt = 0;
		if (!e) mem[a] = d;
	endtask : start
	always @(posedge write_strobe_n_i) if (!chip_select_n_i) begin
		sd[n] = dq_i;
		sa[n] = addr_i;
		n++;
		g = n > 2 && sd[2][7:0] == 8'h60;
		ok = 1;
		for (int i = 0; i < n && i < (g ? 3 : 5); i++) if (sd[i][7:0] != ((i == 2 && g) ? 8'h60 : pc[i])
			|| sa[i][10:0] != pa[i]) ok = 0;
		case (sd[0][7:0])
			8'hF0: begin fail_q = 0; busy = 0; n = 0; end
			8'hB0: begin susp_q = busy; n = 0; end
			8'h30: begin susp_q = 0; n = 0; end
			8'hA0: if (n == 2) begin start(0, sa[1], sd[1]); n = 0; end
			8'h40: if (n == 3) begin mem[sa[1]] = sd[1]; start(0, sa[2], sd[2]); n = 0; end
			8'h90: if (n == 2) begin left_n += int'(sd[1] == 0); n = 0; end
			8'hAA: if (!ok) n = 0;
				else if (g && n == 4) begin guard_q = sd[3][7:0]; n = 0; end
				else if (n == 6) begin
					wipe_q = sd[5][7:0];
					bank_w = wipe_q == 8'h10;
					if (bank_w || wipe_q == 8'h30) start(1, sa[5], 16'hFFFF);
					n = 0;
				end
			default: n = 0;
		endcase
	end
	always @(negedge output_strobe_n_i) #1 if (!chip_select_n_i) begin
		hit = susp_q ? addr_i[20:12] == ta[20:12] : addr_i[20] == ta[20];
		if (busy && hit) begin
			rd = {8'h00, susp_q | (!er & ~pd[7]), susp_q | tog, fail_q, 2'b10,
				susp_q ? tog : (er ? fail_q & tog : 1'b1), 2'b11};
			tog = ~tog;
			if (fail_i) fail_q = 1;
			else if (!hang_i && !susp_q && ++cnt >= 3) begin
				busy = 0;
				if (er) foreach (mem[k]) if (bank_w ? k[20] == ta[20] : k[20:12] == ta[20:12]) mem[k] = 16'hFFFF;
			end
		end else rd = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
	end
endmodule : flash_dev_model

// *** bench/flash_command_status_poll_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
	$display("Error t=%0t got %h exp %h", $time, a, e); end end
module flash_command_status_poll_tb;
	import flash_host_pkg::*;
	logic core_clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, dq_oe_o, fail_i, hang_i;
	logic chip_select_n_o, write_strobe_n_o, output_strobe_n_o;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [20:0] addr_o;
	logic [15:0] dq_out_o, dq_in_i;
	logic [7:0] gc [0:2] = '{8'h01, 8'hD0, 8'h2F};
	int failures, n_compared;
	flash_host_ctrl #(.poll_limit(20)) u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .addr_o(addr_o), .dq_out_o(dq_out_o), .dq_oe_o(dq_oe_o), .dq_in_i(dq_in_i),
		.chip_select_n_o(chip_select_n_o), .write_strobe_n_o(write_strobe_n_o),
		.output_strobe_n_o(output_strobe_n_o));
	flash_dev_model u_dev (.addr_i(addr_o), .dq_i(dq_out_o), .dq_oe_i(dq_oe_o), .chip_select_n_i(chip_select_n_o),
		.write_strobe_n_i(write_strobe_n_o), .output_strobe_n_i(output_strobe_n_o), .fail_i(fail_i),
		.hang_i(hang_i), .dq_o(dq_in_i));
	task final_report;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1;
		k = 0;
		do begin @(posedge core_clk_i); k++; end while (pready !== 1'b1 && k < 100);
		if (k >= 100) failures++;
		r = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk_i);
	endtask : apb
	task run(input host_op_t op, input logic [20:0] a, input logic [15:0] d, input logic [15:0] d2);
		int k;
		apb(1, addr_off, 32'(a));
		apb(1, data_off, 32'(d));
		apb(1, data2_off, 32'(d2));
		apb(1, ctrl_off, 32'h0000_0100 | 32'(op));
		k = 0;
		do begin apb(0, stat_off, 0); k++; end while (r[busy_bit] !== 1'b0 && k < 3000);
		if (k >= 3000) failures++;
	endtask : run
	initial begin
		core_clk_i = 0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial begin
		#1_000_000;
		failures++;
		final_report();
	end
	initial begin
		{rst_b_i, psel, penable, pwrite, paddr, pwdata, fail_i, hang_i, failures, n_compared} = '0;
		repeat (5) @(posedge core_clk_i);
		rst_b_i <= 1;
		apb(0, stat_off, 0);
		`CHK(r, 32'h0000_0000)
		apb(1, 8'h1C, 32'hFFFF_FFFF);
		apb(0, 8'h1C, 0);
		`CHK(r, 32'h0000_0000)
		run(op_bypass_word, 21'h1A_B123, 16'h00A5, 0);
		`CHK(r[3:0], 4'b0010)
		run(op_read, 21'h1A_B123, 0, 0);
		apb(0, rdata_off, 0);
		`CHK(r[15:0], 16'h00A5)
		run(op_bypass_pair, 21'h0_0100, 16'h1111, 16'h2222);
		`CHK(u_dev.mem[21'h0_0101], 16'h2222)
		for (int i = 0; i < 3; i++) begin
			run(host_op_t'(4'h5 + 4'(i)), 21'h1F_F000, 0, 0);
			`CHK(u_dev.guard_q, gc[i])
		end
		run(op_block_wipe, 21'h0_0155, 0, 0);
		`CHK(u_dev.wipe_q, 8'h30)
		`CHK(u_dev.mem[21'h0_0101], 16'hFFFF)
		`CHK(u_dev.mem[21'h1A_B123], 16'h00A5)
		run(op_bank_wipe, 21'h1F_F000, 0, 0);
		`CHK(u_dev.wipe_q, 8'h10)
		`CHK(u_dev.mem[21'h1A_B123], 16'hFFFF)
		run(op_leave_bypass, 21'h1F_FFFF, 0, 0);
		`CHK(u_dev.left_n, 1)
		fail_i <= 1;
		run(op_bypass_word, 21'h0_0002, 16'h1234, 0);
		`CHK(r[fail_bit], 1'b1)
		fail_i <= 0;
		run(op_reset, 0, 0, 0);
		`CHK(u_dev.fail_q, 1'b0)
		hang_i <= 1;
		run(op_bypass_word, 21'h0_0003, 16'h0080, 0);
		`CHK(r[timeout_bit], 1'b1)
		run(op_reset, 0, 0, 0);
		run(op_block_wipe, 21'h0_0100, 0, 0);
		run(op_pause, 0, 0, 0);
		`CHK(u_dev.susp_q, 1'b1)
		hang_i <= 0;
		run(op_continue, 21'h0_0000, 0, 0);
		`CHK(u_dev.susp_q, 1'b0)
		`CHK(r[done_bit], 1'b1)
		final_report();
	end
endmodule : flash_command_status_poll_tb
